// ===== dpm_mapper.v
// Payload mapper placing user bit or byte streams into tagged sub-block bits
`timescale 1ns/1ns
`include "dpm_map.vh"

module dpm_mapper #(
  parameter MAX_PAIRS = 4,
  parameter PAIR_W = 2
) (
  input wire core_clk_in,
  input wire nrst_in,
  input wire enable_in,
  input wire [`DPM_MODE_W-1:0] mode_in,
  input wire [`DPM_N_W-1:0] n_slots_in,
  input wire [`DPM_I_W-1:0] i_bits_in,
  input wire [PAIR_W:0] pairs_in,
  input wire bit_in,
  input wire bit_valid_in,
  output wire bit_ready_out,
  input wire [7:0] byte_in,
  input wire byte_valid_in,
  input wire frame_start_in,
  output wire byte_ready_out,
  output wire map_valid_out,
  output wire map_bit_out,
  output wire [PAIR_W-1:0] map_pair_out,
  output wire [`DPM_POS_W-1:0] map_pos_out,
  output wire map_sob_out,
  output wire slip_out,
  output wire running_out,
  output wire cfg_err_out
);

  // ************************************
  // Helpers
  // ************************************
  function is_byte_mode;
    input [`DPM_MODE_W-1:0] m;
    begin
      is_byte_mode = (m == `DPM_MODE_CLEAR_BYTE) || (m == `DPM_MODE_ALIGNED);
    end
  endfunction

  function in_range;
    input [`DPM_N_W-1:0] v;
    input [`DPM_N_W-1:0] lo;
    input [`DPM_N_W-1:0] hi;
    begin
      in_range = (v >= lo) && (v <= hi);
    end
  endfunction

  function cfg_ok;
    input [`DPM_MODE_W-1:0] m;
    input [`DPM_N_W-1:0] n;
    input [`DPM_I_W-1:0] i;
    input [PAIR_W:0] p;
    reg [PAIR_W+`DPM_N_W:0] tot;
    begin
      tot = p * n;
      cfg_ok = 1'b0;
      if (p != 0 && p <= MAX_PAIRS) begin
        case (m)
          `DPM_MODE_CLEAR_BIT,
          `DPM_MODE_UNSTRUCT: begin
            cfg_ok = in_range(n, `DPM_N_MIN, `DPM_N_MAX);
          end
          `DPM_MODE_CLEAR_BYTE: begin
            cfg_ok = (i == `DPM_I_NONE) && in_range(n, `DPM_N_MIN, `DPM_N_MAX);
          end
          `DPM_MODE_UNALIGNED: begin
            cfg_ok = (i == `DPM_I_NONE) && (n == `DPM_N_FULL_FRAME) && (p == 1);
          end
          `DPM_MODE_ALIGNED: begin
            if (p == 1) begin
              cfg_ok = (i == `DPM_I_NONE) && in_range(n, `DPM_N_MIN, `DPM_N_FULL_FRAME);
            end else begin
              cfg_ok = (i == `DPM_I_NONE) && !tot[0] &&
                       ((tot == `DPM_N_FULL_FRAME) ||
                        in_range(n, `DPM_N_MIN, `DPM_N_MULTI_FRAC_MAX));
            end
          end
          default: begin
            cfg_ok = 1'b0;
          end
        endcase
      end
    end
  endfunction

  // ************************************
  // State
  // ************************************
  reg [`DPM_MODE_W-1:0] mode_ff, nxt_mode;
  reg [`DPM_N_W-1:0] n_ff, nxt_n;
  reg [`DPM_I_W-1:0] i_ff, nxt_i;
  reg [PAIR_W:0] m_ff, nxt_m;
  reg run_ff, nxt_run;
  reg err_ff, nxt_err;
  reg [`DPM_POS_W-1:0] pos_ff, nxt_pos;
  reg [PAIR_W-1:0] pair_ff, nxt_pair;
  reg [`DPM_N_W-1:0] slot_ff, nxt_slot;
  reg [2:0] bidx_ff, nxt_bidx;
  reg [7:0] sr_ff, nxt_sr;
  reg busy_ff, nxt_busy;
  reg bit_rdy_ff, nxt_bit_rdy;
  reg byte_rdy_ff, nxt_byte_rdy;
  reg mv_ff, nxt_mv;
  reg mb_ff, nxt_mb;
  reg [PAIR_W-1:0] mp_ff, nxt_mp;
  reg [`DPM_POS_W-1:0] mpos_ff, nxt_mpos;
  reg sob_ff, nxt_sob;
  reg slip_ff, nxt_slip;
  reg [`DPM_POS_W-1:0] ks_last;
  reg at_start;

  // ************************************
  // Next state
  // ************************************
  always @* begin
    nxt_mode = mode_ff;
    nxt_n = n_ff;
    nxt_i = i_ff;
    nxt_m = m_ff;
    nxt_run = run_ff;
    nxt_err = err_ff;
    nxt_pos = pos_ff;
    nxt_pair = pair_ff;
    nxt_slot = slot_ff;
    nxt_bidx = bidx_ff;
    nxt_sr = sr_ff;
    nxt_busy = busy_ff;
    nxt_mv = 1'b0;
    nxt_mb = mb_ff;
    nxt_mp = mp_ff;
    nxt_mpos = mpos_ff;
    nxt_sob = 1'b0;
    nxt_slip = 1'b0;
    ks_last = {n_ff, 3'h0} + {{(`DPM_POS_W-`DPM_I_W){1'b0}}, i_ff} - 9'h001;
    at_start = (pos_ff == 0) && (pair_ff == 0) && (slot_ff == 0) && !busy_ff;
    if (at_start || !run_ff) begin
      nxt_mode = mode_in;
      nxt_n = n_slots_in;
      nxt_i = i_bits_in;
      nxt_m = pairs_in;
      nxt_err = enable_in && !cfg_ok(mode_in, n_slots_in, i_bits_in, pairs_in);
      nxt_run = enable_in && cfg_ok(mode_in, n_slots_in, i_bits_in, pairs_in);
      if (!nxt_run) begin
        nxt_pos = {`DPM_POS_W{1'b0}};
        nxt_pair = {PAIR_W{1'b0}};
        nxt_slot = {`DPM_N_W{1'b0}};
        nxt_busy = 1'b0;
      end
    end
    if (run_ff && !is_byte_mode(mode_ff) && bit_valid_in && bit_rdy_ff) begin
      nxt_mv = 1'b1;
      nxt_mb = bit_in;
      nxt_mp = pair_ff;
      nxt_mpos = pos_ff;
      nxt_sob = (pos_ff == 0) && (pair_ff == 0);
      if (pos_ff == ks_last) begin
        nxt_pos = {`DPM_POS_W{1'b0}};
        nxt_pair = (pair_ff == m_ff - 1) ? {PAIR_W{1'b0}} : pair_ff + 1'b1;
      end else begin
        nxt_pos = pos_ff + 1'b1;
      end
    end
    if (run_ff && busy_ff) begin
      nxt_mv = 1'b1;
      nxt_mb = sr_ff[0];
      nxt_mp = pair_ff;
      nxt_mpos = {slot_ff, bidx_ff};
      nxt_sob = (slot_ff == 0) && (pair_ff == 0) && (bidx_ff == 0);
      nxt_sr = {1'b0, sr_ff[7:1]};
      nxt_bidx = bidx_ff + 1'b1;
      if (bidx_ff == `DPM_LAST_BIT) begin
        nxt_busy = 1'b0;
        if (pair_ff == m_ff - 1) begin
          nxt_pair = {PAIR_W{1'b0}};
          nxt_slot = (slot_ff == n_ff - 1) ? {`DPM_N_W{1'b0}} : slot_ff + 1'b1;
        end else begin
          nxt_pair = pair_ff + 1'b1;
        end
      end
    end else if (run_ff && is_byte_mode(mode_ff) && byte_valid_in && byte_rdy_ff) begin
      nxt_sr = byte_in;
      nxt_busy = 1'b1;
      nxt_bidx = 3'h0;
      if (mode_ff == `DPM_MODE_ALIGNED && frame_start_in && !at_start) begin
        nxt_slot = {`DPM_N_W{1'b0}};
        nxt_pair = {PAIR_W{1'b0}};
        nxt_slip = 1'b1;
      end
    end
    nxt_bit_rdy = nxt_run && !is_byte_mode(nxt_mode);
    nxt_byte_rdy = nxt_run && is_byte_mode(nxt_mode) && !nxt_busy;
  end

  // ************************************
  // Registers
  // ************************************
  // Async reset loads constants only
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_ff <= `DPM_MODE_CLEAR_BIT;
      n_ff <= `DPM_N_MIN;
      i_ff <= `DPM_I_NONE;
      m_ff <= {{PAIR_W{1'b0}}, 1'b1};
      run_ff <= 1'b0;
      err_ff <= 1'b0;
      pos_ff <= {`DPM_POS_W{1'b0}};
      pair_ff <= {PAIR_W{1'b0}};
      slot_ff <= {`DPM_N_W{1'b0}};
      bidx_ff <= 3'h0;
      sr_ff <= 8'h00;
      busy_ff <= 1'b0;
      bit_rdy_ff <= 1'b0;
      byte_rdy_ff <= 1'b0;
      mv_ff <= 1'b0;
      mb_ff <= 1'b0;
      mp_ff <= {PAIR_W{1'b0}};
      mpos_ff <= {`DPM_POS_W{1'b0}};
      sob_ff <= 1'b0;
      slip_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      n_ff <= nxt_n;
      i_ff <= nxt_i;
      m_ff <= nxt_m;
      run_ff <= nxt_run;
      err_ff <= nxt_err;
      pos_ff <= nxt_pos;
      pair_ff <= nxt_pair;
      slot_ff <= nxt_slot;
      bidx_ff <= nxt_bidx;
      sr_ff <= nxt_sr;
      busy_ff <= nxt_busy;
      bit_rdy_ff <= nxt_bit_rdy;
      byte_rdy_ff <= nxt_byte_rdy;
      mv_ff <= nxt_mv;
      mb_ff <= nxt_mb;
      mp_ff <= nxt_mp;
      mpos_ff <= nxt_mpos;
      sob_ff <= nxt_sob;
      slip_ff <= nxt_slip;
    end
  end

  // ************************************
  // Outputs
  // ************************************
  assign bit_ready_out = bit_rdy_ff;
  assign byte_ready_out = byte_rdy_ff;
  assign map_valid_out = mv_ff;
  assign map_bit_out = mb_ff;
  assign map_pair_out = mp_ff;
  assign map_pos_out = mpos_ff;
  assign map_sob_out = sob_ff;
  assign slip_out = slip_ff;
  assign running_out = run_ff;
  assign cfg_err_out = err_ff;

endmodule // dpm_mapper

// ===== dpm_map.vh
// Constants for the payload mapper: mode codes, slot limits, field widths
`ifndef DPM_MAP_VH
`define DPM_MAP_VH

// ************************************
// Mapping modes
// ************************************
`define DPM_MODE_CLEAR_BIT 3'h0
`define DPM_MODE_CLEAR_BYTE 3'h1
`define DPM_MODE_UNSTRUCT 3'h2
`define DPM_MODE_UNALIGNED 3'h3
`define DPM_MODE_ALIGNED 3'h4

// ************************************
// Slot count limits and bit constants
// ************************************
`define DPM_N_MIN 6'h03
`define DPM_N_MAX 6'h24
`define DPM_N_FULL_FRAME 6'h20
`define DPM_N_MULTI_FRAC_MAX 6'h10
`define DPM_I_NONE 3'h0
`define DPM_BYTE_BITS 4'h8
`define DPM_LAST_BIT 3'h7

// ************************************
// Field widths
// ************************************
`define DPM_MODE_W 3
`define DPM_N_W 6
`define DPM_I_W 3
`define DPM_POS_W 9

`endif

// ===== dpm_mapper_asserts.sv
// Output timing checks for the payload mapper
`timescale 1ns/1ns
`include "dpm_map.vh"
module dpm_mapper_asserts #(
  parameter PAIR_W = 2
) (
  input wire core_clk_in,
  input wire nrst_in,
  input wire [`DPM_MODE_W-1:0] mode_in,
  input wire [`DPM_N_W-1:0] n_slots_in,
  input wire bit_in,
  input wire bit_valid_in,
  input wire bit_ready_out,
  input wire [7:0] byte_in,
  input wire byte_valid_in,
  input wire byte_ready_out,
  input wire map_valid_out,
  input wire map_bit_out,
  input wire [PAIR_W-1:0] map_pair_out,
  input wire [`DPM_POS_W-1:0] map_pos_out,
  input wire map_sob_out,
  input wire running_out,
  input wire cfg_err_out
);
  // ****
  // Port relations
  // ****
  wire take = byte_valid_in && byte_ready_out;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);
  chk_bit_order:
    assert property (bit_valid_in && bit_ready_out |=> map_valid_out && map_bit_out == $past(bit_in))
    else $error("bit not passed");
  chk_byte_busy:
    assert property (take |=> !byte_ready_out [*8] ##1 byte_ready_out)
    else $error("byte ready spacing");
  chk_byte_burst:
    assert property (take |=> !map_valid_out ##1 map_valid_out [*8])
    else $error("byte burst");
  chk_lsb_first:
    assert property (take |-> ##2 map_bit_out == $past(byte_in[0], 2)
      ##7 map_bit_out == $past(byte_in[7], 9))
    else $error("byte bit order");
  chk_sob_start:
    assert property (map_sob_out |-> map_valid_out && map_pos_out == 0 && map_pair_out == 0)
    else $error("sub-block start");
  chk_cfg_refuse:
    assert property (cfg_err_out |-> !running_out && !bit_ready_out && !byte_ready_out)
    else $error("refused config runs");
  chk_unal_single:
    assert property (map_valid_out && mode_in == `DPM_MODE_UNALIGNED |-> map_pair_out == 0)
    else $error("unaligned on pair");
  chk_byte_span:
    assert property (map_valid_out && mode_in == `DPM_MODE_CLEAR_BYTE
      |-> map_pos_out < {n_slots_in, 3'h0})
    else $error("slot past n");
endmodule // dpm_mapper_asserts

// ===== dpm_user_src.sv
// User-side stream source standing in for the line interface framer
`timescale 1ns/1ns
module dpm_user_src (
  input wire core_clk_in,
  input wire bit_ready_in,
  input wire byte_ready_in,
  output reg bit_out = 1'b0,
  output reg bit_valid_out = 1'b0,
  output reg [7:0] byte_out = 8'h00,
  output reg byte_valid_out = 1'b0,
  output reg frame_start_out = 1'b0
);
  reg [11:0] exp_q[$];
  integer k = 0;
  // ****
  // Unit sender, held until taken
  // ****
  task send(input integer units, input integer ks, input integer m, input integer slip_at);
    integer u;
    integer b;
    reg [7:0] d;
    begin
      for (u = 0; u < units; u = u + 1) begin
        d = $urandom;
        if (bit_ready_in) begin
          exp_q.push_back({2'((k / ks) % m), 9'(k % ks), d[0]});
          bit_out <= d[0];
          bit_valid_out <= 1'b1;
        end else begin
          // frame start on slot 0, pair 0; a misplaced one restarts the count
          if (u == slip_at)
            k = 0;
          frame_start_out <= (k % (ks / 8 * m) == 0);
          for (b = 0; b < 8; b = b + 1)
            exp_q.push_back({2'(k % m), 9'((k / m) % (ks / 8) * 8 + b), d[b]});
          byte_out <= d;
          byte_valid_out <= 1'b1;
        end
        k = k + 1;
        @(posedge core_clk_in);
        while (!(bit_ready_in && bit_valid_out) && !(byte_ready_in && byte_valid_out))
          @(posedge core_clk_in);
      end
      // Released lines flip so stale data cannot match
      bit_valid_out <= 1'b0;
      byte_valid_out <= 1'b0;
      frame_start_out <= 1'b0;
      bit_out <= ~bit_out;
      byte_out <= ~byte_out;
    end
  endtask
endmodule // dpm_user_src

// ===== tb_top.sv
// Testbench for the payload mapper: modes, pairs and refused settings
`timescale 1ns/1ns
`include "dpm_map.vh"
module tb_top;
  reg core_clk_in = 1'b0;
  reg nrst_in = 1'b0;
  reg [2:0] mode_in = 3'h0;
  reg [5:0] n_slots_in = 6'h03;
  reg [2:0] i_bits_in = 3'h0;
  reg [2:0] pairs_in = 3'h1;
  wire enable_in = 1'b1;
  wire frame_start_in;
  wire bit_in, bit_valid_in, bit_ready_out, byte_valid_in, byte_ready_out;
  wire [7:0] byte_in;
  wire map_valid_out, map_bit_out, map_sob_out, slip_out, running_out, cfg_err_out;
  wire [1:0] map_pair_out;
  wire [8:0] map_pos_out;
  integer error_cnt = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer slip_cnt = 0;
  reg [11:0] exp_v;
  always #4 core_clk_in = ~core_clk_in;
  dpm_mapper dpm_mapper_inst (.core_clk_in, .nrst_in, .enable_in, .mode_in, .n_slots_in,
    .i_bits_in, .pairs_in, .bit_in, .bit_valid_in, .bit_ready_out, .byte_in, .byte_valid_in,
    .frame_start_in, .byte_ready_out, .map_valid_out, .map_bit_out, .map_pair_out,
    .map_pos_out, .map_sob_out, .slip_out, .running_out, .cfg_err_out);
  dpm_user_src dpm_user_src_inst (.core_clk_in(core_clk_in), .bit_ready_in(bit_ready_out),
    .byte_ready_in(byte_ready_out), .bit_out(bit_in), .bit_valid_out(bit_valid_in),
    .byte_out(byte_in), .byte_valid_out(byte_valid_in), .frame_start_out(frame_start_in));
  task check(input string what, input [11:0] exp, input [11:0] got);
    begin
      tests_run = tests_run + 1;
      if (exp !== got) begin
        error_cnt = error_cnt + 1;
        $display("BAD %s exp %h seen %h", what, exp, got);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // ****
  // Result watcher and hang limit
  // ****
  always @(posedge core_clk_in) begin
    cyc = cyc + 1;
    if (cyc == 10000) begin
      error_cnt = error_cnt + 1;
      print_verdict;
    end else begin
      if (slip_out === 1'b1)
        slip_cnt = slip_cnt + 1;
      if (map_valid_out === 1'b1) begin
        exp_v = 12'hFFF;
        if (dpm_user_src_inst.exp_q.size() > 0)
          exp_v = dpm_user_src_inst.exp_q.pop_front();
        check("map", exp_v, {map_pair_out, map_pos_out, map_bit_out});
        check("sob", {11'h000, exp_v[11:1] == 11'h000}, {11'h000, map_sob_out});
      end
    end
  end
  // Fresh reset per test so slot counters restart at zero
  task run(input [2:0] md, input [5:0] n, input [2:0] i, input [2:0] m, input integer units,
    input integer ks, input integer slip_at);
    begin
      nrst_in <= 1'b0;
      mode_in <= md;
      n_slots_in <= n;
      i_bits_in <= i;
      pairs_in <= m;
      repeat (3) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      dpm_user_src_inst.k = 0;
      slip_cnt = 0;
      check("cfg", {10'h0, units != 0, units == 0}, {10'h0, running_out, cfg_err_out});
      if (units != 0)
        dpm_user_src_inst.send(units, ks, m, slip_at);
      repeat (12) @(posedge core_clk_in);
      check("left", 12'h0, 12'(dpm_user_src_inst.exp_q.size()));
      // One pulse per misplaced frame start, none on true boundaries
      check("slip", {11'h000, slip_at > 0}, 12'(slip_cnt));
      $display("test mode %0d n %0d pairs %0d done", md, n, m);
    end
  endtask
  initial begin
    void'($urandom(32'h9954));
    run(`DPM_MODE_CLEAR_BIT, 6'h03, 3'h2, 3'h1, 60, 26, -1);
    run(`DPM_MODE_UNSTRUCT, 6'h03, 3'h2, 3'h1, 60, 26, -1);
    run(`DPM_MODE_CLEAR_BIT, 6'h03, 3'h0, 3'h4, 200, 24, -1);
    run(`DPM_MODE_CLEAR_BYTE, 6'h03, 3'h0, 3'h1, 10, 24, -1);
    run(`DPM_MODE_CLEAR_BYTE, 6'h24, 3'h0, 3'h1, 40, 288, -1);
    run(`DPM_MODE_CLEAR_BYTE, 6'h04, 3'h0, 3'h2, 20, 32, -1);
    run(`DPM_MODE_UNALIGNED, 6'h20, 3'h0, 3'h1, 40, 256, -1);
    run(`DPM_MODE_ALIGNED, 6'h10, 3'h0, 3'h2, 40, 128, -1);
    run(`DPM_MODE_ALIGNED, 6'h05, 3'h0, 3'h2, 30, 40, 3);
    run(`DPM_MODE_CLEAR_BYTE, 6'h02, 3'h0, 3'h1, 0, 0, -1);
    run(`DPM_MODE_UNALIGNED, 6'h20, 3'h0, 3'h2, 0, 0, -1);
    run(`DPM_MODE_ALIGNED, 6'h11, 3'h0, 3'h2, 0, 0, -1);
    print_verdict;
  end
endmodule // tb_top
bind dpm_mapper dpm_mapper_asserts #(.PAIR_W(PAIR_W)) dpm_mapper_asserts_inst (.core_clk_in,
  .nrst_in, .mode_in, .n_slots_in, .bit_in, .bit_valid_in, .bit_ready_out, .byte_in,
  .byte_valid_in, .byte_ready_out, .map_valid_out, .map_bit_out, .map_pair_out, .map_pos_out,
  .map_sob_out, .running_out, .cfg_err_out);
